// File: rrn_top.sv
// relay node: network link receiver and replier, relay control, watchdog, avalon registers
// assumes one clock, synchronous reset, switches and status inputs straight from pins
`include "rrn_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module rrn_top #(
   parameter logic [17:0] BAUD_FAST_DIV = 18'(`RRN_FAST_DIV),
   parameter logic [17:0] BAUD_SLOW_DIV = 18'(`RRN_SLOW_DIV),
   parameter logic [31:0] WDOG_CYCLES   = 32'(`RRN_WDOG_CYC),
   parameter logic [31:0] PULSE_CYCLES  = 32'(`RRN_PULSE_CYC),
   parameter logic [17:0] DEB_CYCLES    = 18'(`RRN_DEB_CYC)
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        net_rx,
   output logic             net_tx,
   output logic             net_tx_en,
   input  wire logic        sw_baud_slow,
   input  wire logic        sw_pulse_en,
   input  wire logic        sw_wdog_en,
   input  wire logic        status_input_one,
   input  wire logic        status_input_two,
   output logic             relay_on
);

   logic [4:0]           raw_in;
   logic [4:0]           clean_in;
   logic                 in_one;
   logic                 in_two;
   logic                 baud_slow;
   logic                 pulse_en;
   logic                 wdog_en;
   logic                 rx_meta;
   logic                 rx_sync;
   logic [17:0]          bit_div;
   logic [17:0]          rx_cnt;
   logic [2:0]           rx_bit;
   logic [7:0]           rx_sh;
   logic                 rx_done;
   logic                 rx_ferr;
   rrn_pkg::rrn_rx_st_t  rx_st;
   rrn_pkg::rrn_ps_st_t  ps_st;
   logic [1:0]           addr_hi;
   logic                 addr_match;
   logic                 msg_ok;
   logic [7:0]           msg_cmd;
   logic [9:0]           node_addr;
   logic [31:0]          wd_cnt;
   logic                 comm_lost;
   logic [31:0]          pulse_cnt;
   logic                 pulse_act;
   logic [15:0]          msg_count;
   logic                 tx_pend;
   rrn_pkg::rrn_tx_st_t  tx_st;
   logic [17:0]          tx_cnt;
   logic [2:0]           tx_bit;
   logic [7:0]           tx_sh;
   logic                 bus_ack;
   logic                 bus_req;
   logic [31:0]          rd_mux;
   logic [7:0]           status_bits;

   // synchronise and debounce switches and status inputs
   assign raw_in = {sw_wdog_en, sw_pulse_en, sw_baud_slow, status_input_two, status_input_one};

   for (genvar i = 0; i < 5; i++) begin : g_deb
      rrn_debounce #(
         .DEB_CYCLES (DEB_CYCLES)
      ) u_deb (
         .clk    (clk),
         .resetn (resetn),
         .din    (raw_in[i]),
         .dout   (clean_in[i])
      );
   end

   assign in_one    = clean_in[0];
   assign in_two    = clean_in[1];
   assign baud_slow = clean_in[2];
   assign pulse_en  = clean_in[3];
   assign wdog_en   = clean_in[4];

   // bit period picked by the baud switch
   assign bit_div = baud_slow ? BAUD_SLOW_DIV : BAUD_FAST_DIV;

   // receive line synchroniser, idle high
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end else begin
         rx_meta <= net_rx;
         rx_sync <= rx_meta;
      end
   end

   // byte receiver, 8 data bits lsb first, one stop bit, sampled mid bit
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_st   <= rrn_pkg::rx_idle;
         rx_cnt  <= 18'h00000;
         rx_bit  <= 3'h0;
         rx_sh   <= 8'h00;
         rx_done <= 1'b0;
         rx_ferr <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         rx_ferr <= 1'b0;
         unique case (rx_st)
            rrn_pkg::rx_idle: begin
               if (!rx_sync) begin
                  rx_st  <= rrn_pkg::rx_start;
                  rx_cnt <= {1'b0, bit_div[17:1]};
               end
            end
            rrn_pkg::rx_start: begin
               if (rx_cnt != 18'h00000) begin
                  rx_cnt <= rx_cnt - 18'd1;
               end else if (rx_sync) begin
                  rx_st <= rrn_pkg::rx_idle; // glitch, not a start bit
               end else begin
                  rx_st  <= rrn_pkg::rx_data;
                  rx_cnt <= bit_div - 18'd1;
                  rx_bit <= 3'h0;
               end
            end
            rrn_pkg::rx_data: begin
               if (rx_cnt != 18'h00000) begin
                  rx_cnt <= rx_cnt - 18'd1;
               end else begin
                  rx_sh  <= {rx_sync, rx_sh[7:1]};
                  rx_cnt <= bit_div - 18'd1;
                  if (rx_bit == 3'h7) begin
                     rx_st <= rrn_pkg::rx_stop;
                  end else begin
                     rx_bit <= rx_bit + 3'd1;
                  end
               end
            end
            rrn_pkg::rx_stop: begin
               if (rx_cnt != 18'h00000) begin
                  rx_cnt <= rx_cnt - 18'd1;
               end else begin
                  rx_st   <= rrn_pkg::rx_idle;
                  rx_done <= rx_sync;
                  rx_ferr <= ~rx_sync;
               end
            end
         endcase
      end
   end

   // parser: header with address high bits, address low byte, command
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ps_st      <= rrn_pkg::ps_hdr;
         addr_hi    <= 2'h0;
         addr_match <= 1'b0;
         msg_ok     <= 1'b0;
         msg_cmd    <= 8'h00;
      end else begin
         msg_ok <= 1'b0;
         if (rx_ferr) begin
            ps_st <= rrn_pkg::ps_hdr; // broken frame drops the message
         end else if (rx_done) begin
            unique case (ps_st)
               rrn_pkg::ps_hdr: begin
                  if (rx_sh[7:2] == `RRN_HDR_TAG) begin
                     addr_hi <= rx_sh[1:0];
                     ps_st   <= rrn_pkg::ps_adlo;
                  end
               end
               rrn_pkg::ps_adlo: begin
                  addr_match <= ({addr_hi, rx_sh} == node_addr);
                  ps_st      <= rrn_pkg::ps_cmd;
               end
               rrn_pkg::ps_cmd: begin
                  ps_st   <= rrn_pkg::ps_hdr;
                  msg_cmd <= rx_sh;
                  msg_ok  <= addr_match && (rx_sh == `RRN_CMD_OFF || rx_sh == `RRN_CMD_ON
                                            || rx_sh == `RRN_CMD_POLL);
               end
            endcase
         end
      end
   end

   // watchdog: counts silence, restarted by each valid message, idle when disabled
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wd_cnt    <= 32'h00000000;
         comm_lost <= 1'b0;
      end else if (msg_ok || !wdog_en) begin
         wd_cnt    <= 32'h00000000;
         comm_lost <= 1'b0;
      end else if (wd_cnt >= WDOG_CYCLES - 32'd1) begin
         comm_lost <= 1'b1;
      end else begin
         wd_cnt <= wd_cnt + 32'd1;
      end
   end

   // relay state: commands first, then watchdog drop, then pulse timeout
   always_ff @(posedge clk) begin
      if (!resetn) begin
         relay_on  <= 1'b0;
         pulse_act <= 1'b0;
         pulse_cnt <= 32'h00000000;
      end else if (msg_ok && msg_cmd == `RRN_CMD_ON) begin
         relay_on  <= 1'b1;
         pulse_act <= pulse_en;
         pulse_cnt <= PULSE_CYCLES - 32'd1;
      end else if (msg_ok && msg_cmd == `RRN_CMD_OFF) begin
         relay_on  <= 1'b0;
         pulse_act <= 1'b0;
      end else if (comm_lost && wdog_en) begin
         relay_on  <= 1'b0;
         pulse_act <= 1'b0;
      end else if (pulse_act && !pulse_en) begin
         pulse_act <= 1'b0;
      end else if (pulse_act) begin
         if (pulse_cnt == 32'h00000000) begin
            relay_on  <= 1'b0;
            pulse_act <= 1'b0;
         end else begin
            pulse_cnt <= pulse_cnt - 32'd1;
         end
      end
      // otherwise the relay holds its last commanded state
   end

   // count of valid messages seen
   always_ff @(posedge clk) begin
      if (!resetn) begin
         msg_count <= 16'h0000;
      end else if (msg_ok) begin
         msg_count <= msg_count + 16'd1;
      end
   end

   // status byte reported to software; the reply to the master carries only its low three bits
   assign status_bits = {wdog_en, pulse_en, baud_slow, pulse_act, comm_lost, in_two, in_one, relay_on};

   // reply request, set by a valid message, taken by the transmitter
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_pend <= 1'b0;
      end else if (msg_ok) begin
         tx_pend <= 1'b1;
      end else if (tx_st == rrn_pkg::tx_idle) begin
         tx_pend <= 1'b0;
      end
   end

   // reply transmitter, drives the line only while sending
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_st     <= rrn_pkg::tx_idle;
         tx_cnt    <= 18'h00000;
         tx_bit    <= 3'h0;
         tx_sh     <= 8'h00;
         net_tx    <= 1'b1;
         net_tx_en <= 1'b0;
      end else begin
         unique case (tx_st)
            rrn_pkg::tx_idle: begin
               net_tx    <= 1'b1;
               net_tx_en <= 1'b0;
               if (tx_pend) begin
                  tx_sh     <= {`RRN_RPL_TAG, in_two, in_one, relay_on};
                  tx_st     <= rrn_pkg::tx_start;
                  tx_cnt    <= bit_div - 18'd1;
                  net_tx    <= 1'b0;
                  net_tx_en <= 1'b1;
               end
            end
            rrn_pkg::tx_start: begin
               if (tx_cnt != 18'h00000) begin
                  tx_cnt <= tx_cnt - 18'd1;
               end else begin
                  tx_st  <= rrn_pkg::tx_data;
                  tx_cnt <= bit_div - 18'd1;
                  tx_bit <= 3'h0;
                  net_tx <= tx_sh[0];
                  tx_sh  <= {1'b0, tx_sh[7:1]};
               end
            end
            rrn_pkg::tx_data: begin
               if (tx_cnt != 18'h00000) begin
                  tx_cnt <= tx_cnt - 18'd1;
               end else if (tx_bit == 3'h7) begin
                  tx_st  <= rrn_pkg::tx_stop;
                  tx_cnt <= bit_div - 18'd1;
                  net_tx <= 1'b1;
               end else begin
                  tx_bit <= tx_bit + 3'd1;
                  tx_cnt <= bit_div - 18'd1;
                  net_tx <= tx_sh[0];
                  tx_sh  <= {1'b0, tx_sh[7:1]};
               end
            end
            rrn_pkg::tx_stop: begin
               if (tx_cnt != 18'h00000) begin
                  tx_cnt <= tx_cnt - 18'd1;
               end else begin
                  tx_st     <= rrn_pkg::tx_idle;
                  net_tx_en <= 1'b0;
               end
            end
         endcase
      end
   end

   // avalon slave: one wait state on every access
   assign bus_req         = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~bus_ack;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         bus_ack <= 1'b0;
      end else begin
         bus_ack <= bus_req & ~bus_ack;
      end
   end

   // read decode, unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h00000000;
      case (avs_address)
         `RRN_REG_NODE_ADDR: rd_mux = {22'h000000, node_addr};
         `RRN_REG_STATUS:    rd_mux = {24'h000000, status_bits};
         `RRN_REG_MSG_COUNT: rd_mux = {16'h0000, msg_count};
         default:            rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !bus_ack) begin
         avs_readdata <= rd_mux;
      end
   end

   // node address register, written at the edge that completes the access
   always_ff @(posedge clk) begin
      if (!resetn) begin
         node_addr <= `RRN_NODE_ADDR_RST;
      end else if (avs_write && bus_ack && avs_address == `RRN_REG_NODE_ADDR) begin
         if (avs_byteenable[0]) begin
            node_addr[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            node_addr[9:8] <= avs_writedata[9:8];
         end
      end
   end

endmodule

`default_nettype wire

// File: rrn_defines.svh
// offsets, field positions, reset values, codes and timing counts of the relay node
// assumes a single 250 MHz device clock
`ifndef RRN_DEFINES_SVH
`define RRN_DEFINES_SVH

// register byte offsets on the avalon slave
`define RRN_REG_NODE_ADDR   4'h0
`define RRN_REG_STATUS      4'h4
`define RRN_REG_MSG_COUNT   4'h8

// status register field positions
`define RRN_ST_RELAY        0
`define RRN_ST_IN_ONE       1
`define RRN_ST_IN_TWO       2
`define RRN_ST_LOST         3
`define RRN_ST_PULSE        4
`define RRN_ST_SW_SLOW      5
`define RRN_ST_SW_PULSE     6
`define RRN_ST_SW_WDOG      7

// reset values
`define RRN_NODE_ADDR_RST   10'h001

// message framing codes
`define RRN_HDR_TAG         6'h29
`define RRN_RPL_TAG         5'h14
`define RRN_CMD_OFF         8'h00
`define RRN_CMD_ON          8'h01
`define RRN_CMD_POLL        8'h02

// times in their own units
`define RRN_CLK_HZ          250000000
`define RRN_BAUD_FAST       9600
`define RRN_BAUD_SLOW       1200
`define RRN_WDOG_S          10
`define RRN_PULSE_S         10
`define RRN_DEB_US          1000

// derived cycle counts
`define RRN_FAST_DIV  ((`RRN_CLK_HZ + `RRN_BAUD_FAST / 2) / `RRN_BAUD_FAST)
`define RRN_SLOW_DIV  ((`RRN_CLK_HZ + `RRN_BAUD_SLOW / 2) / `RRN_BAUD_SLOW)
`define RRN_WDOG_CYC  (64'(`RRN_CLK_HZ) * 64'(`RRN_WDOG_S))
`define RRN_PULSE_CYC (64'(`RRN_CLK_HZ) * 64'(`RRN_PULSE_S))
`define RRN_DEB_CYC   (`RRN_CLK_HZ / 1000000 * `RRN_DEB_US)

`endif

// File: rrn_pkg.sv
// state types of the relay node
// assumes nothing of its surroundings
package rrn_pkg;

   // serial receiver states
   typedef enum logic [1:0] {rx_idle, rx_start, rx_data, rx_stop} rrn_rx_st_t;

   // serial transmitter states
   typedef enum logic [1:0] {tx_idle, tx_start, tx_data, tx_stop} rrn_tx_st_t;

   // message parser states
   typedef enum logic [1:0] {ps_hdr, ps_adlo, ps_cmd} rrn_ps_st_t;

endpackage

// File: rrn_debounce.sv
// two-flop synchroniser followed by a stability filter for one slow input
// assumes din is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none

module rrn_debounce #(
   parameter logic [17:0] DEB_CYCLES = 18'd250000
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic din,
   output logic      dout
);

   logic        meta;
   logic        sync;
   logic [17:0] cnt;

   // synchroniser, meta is read only by sync
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta <= 1'b0;
         sync <= 1'b0;
      end else begin
         meta <= din;
         sync <= meta;
      end
   end

   // output follows only after the input held a new level for the full count
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt  <= 18'h00000;
         dout <= 1'b0;
      end else if (sync == dout) begin
         cnt <= 18'h00000;
      end else if (cnt >= DEB_CYCLES - 18'd1) begin
         cnt  <= 18'h00000;
         dout <= sync;
      end else begin
         cnt <= cnt + 18'd1;
      end
   end

endmodule

`default_nettype wire

// File: rrn_properties.sv
// checker for the relay node: reply framing, relay timing and watchdog at the top ports
// assumes binding into rrn_top with the same parameter values
`timescale 1ns/1ps
`default_nettype none

module rrn_properties #(
   parameter logic [17:0] BAUD_FAST_DIV = 18'h10,
   parameter logic [17:0] BAUD_SLOW_DIV = 18'h40,
   parameter logic [31:0] WDOG_CYCLES   = 32'h7D0,
   parameter logic [31:0] PULSE_CYCLES  = 32'h5DC,
   parameter logic [17:0] DEB_CYCLES    = 18'h4
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic net_rx,
   input wire logic net_tx,
   input wire logic net_tx_en,
   input wire logic sw_baud_slow,
   input wire logic sw_pulse_en,
   input wire logic sw_wdog_en,
   input wire logic relay_on
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   logic [31:0] wd_cnt;
   logic [31:0] pl_cnt;
   logic [31:0] tx_cnt;
   logic [7:0]  rx_hi;
   logic [7:0]  sw_age;
   logic        pl_arm;

   // silence seen by the master side while the watchdog switch is on; a reply marks a valid message
   always_ff @(posedge clk) begin
      if (!resetn || !sw_wdog_en || net_tx_en) wd_cnt <= 32'h0;
      else wd_cnt <= wd_cnt + 32'h1;
   end

   // a reply in pulse mode arms the on-time count
   always_ff @(posedge clk) begin
      if (!resetn || !sw_pulse_en) pl_arm <= 1'b0;
      else if (net_tx_en) pl_arm <= 1'b1;
   end

   // on-time of an armed pulse, restarted by each reply
   always_ff @(posedge clk) begin
      if (!resetn || !relay_on || !pl_arm || net_tx_en) pl_cnt <= 32'h0;
      else pl_cnt <= pl_cnt + 32'h1;
   end

   // length of the driven reply, idle time of the receive line, age of the switch settings
   always_ff @(posedge clk) begin
      if (!net_tx_en) tx_cnt <= 32'h0;
      else tx_cnt <= tx_cnt + 32'h1;
   end
   always_ff @(posedge clk) begin
      if (!net_rx) rx_hi <= 8'h0;
      else if (rx_hi != 8'hFF) rx_hi <= rx_hi + 8'h1;
   end
   always_ff @(posedge clk) begin
      if (!resetn || $changed({sw_baud_slow, sw_pulse_en, sw_wdog_en})) sw_age <= 8'h0;
      else if (sw_age != 8'hFF) sw_age <= sw_age + 8'h1;
   end

   sequence s_reply_start;
      $rose(net_tx_en);
   endsequence
   sequence s_reply_end;
      $fell(net_tx_en);
   endsequence

   AST_TX_IDLE: assert property (!net_tx_en |-> net_tx)
      else $error("link output not high while the driver is off");
   AST_TX_START: assert property (s_reply_start |-> ##[0:1] !net_tx)
      else $error("reply does not open with a start bit");
   AST_TX_STOP: assert property (s_reply_end |-> $past(net_tx))
      else $error("reply does not close with a stop bit");
   AST_REPLY_LEN: assert property ($fell(net_tx_en) && sw_age == 8'hFF |->
      $past(tx_cnt) + 32'h1 == 32'd10 * 32'(sw_baud_slow ? BAUD_SLOW_DIV : BAUD_FAST_DIV))
      else $error("reply length is not ten bit times");
   AST_REPLY_AFTER_RX: assert property (s_reply_start |-> rx_hi >= 8'h2)
      else $error("reply started while the master line was active");
   AST_HOLD_STATE: assert property ($changed(relay_on) && !sw_wdog_en && !sw_pulse_en &&
      32'(sw_age) > 32'(DEB_CYCLES) + 32'h8 |-> ##[0:3] $rose(net_tx_en))
      else $error("relay changed without a command");
   AST_WDOG_OFF: assert property (wd_cnt > WDOG_CYCLES + 32'(DEB_CYCLES) + 32'h8 |->
      ##4 (!$past(relay_on) || net_tx_en))
      else $error("relay stayed on after the watchdog interval");
   AST_PULSE_END: assert property (relay_on && pl_arm |-> pl_cnt <= PULSE_CYCLES + 32'h8)
      else $error("pulse lasted too long");
endmodule

`default_nettype wire

// File: rrn_master_model.sv
// partner model: master station on the shared serial link
// assumes 8N1 frames, least significant bit first, line idle high, rate given by div
`timescale 1ns/1ps
`default_nettype none

module rrn_master_model (
   input  wire logic        clk,
   input  wire logic [17:0] div,
   input  wire logic        net_tx,
   input  wire logic        net_tx_en,
   output logic             net_rx
);
   logic [7:0] reply_byte;
   logic       reply_stop;
   int         reply_cnt;

   initial begin
      net_rx = 1'b1;
      reply_byte = 8'h00;
      reply_stop = 1'b0;
      reply_cnt = 0;
   end

   // one frame at the rate the node's baud switch selects
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         net_rx <= f[i];
         repeat (div) @(posedge clk);
      end
   endtask

   // message: header with high address bits, low address byte, command; one node per address
   task automatic send_msg(input logic [9:0] addr, input logic [7:0] cmd);
      @(posedge clk);
      send_byte({6'h29, addr[9:8]});
      send_byte(addr[7:0]);
      send_byte(cmd);
   endtask

   // samples each reply frame at bit centres while the node drives the line
   always begin
      @(posedge clk iff (net_tx_en === 1'b1 && net_tx === 1'b0));
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (div) @(posedge clk);
         reply_byte[i] = net_tx;
      end
      repeat (div) @(posedge clk);
      reply_stop = net_tx;
      reply_cnt++;
   end
endmodule

`default_nettype wire

// File: tb_top.sv
// testbench for the relay node: register bus, link messages, relay timing and watchdog
// assumes rrn_top with shortened counts and the master model on the link
`include "rrn_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam logic [17:0] FDIV  = 18'h10;
   localparam logic [17:0] SDIV  = 18'h40;
   localparam logic [31:0] WDOG  = 32'h7D0;
   localparam logic [31:0] PULSE = 32'h5DC;
   localparam logic [17:0] DEB   = 18'h4;

   logic        clk, resetn, avs_read, avs_write, avs_waitrequest, net_rx, net_tx, net_tx_en;
   logic        sw_baud_slow, sw_pulse_en, sw_wdog_en, status_input_one, status_input_two, relay_on;
   logic [3:0]  avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata;
   logic [17:0] div;
   int          mismatches, checked;

   rrn_top #(.BAUD_FAST_DIV(FDIV), .BAUD_SLOW_DIV(SDIV), .WDOG_CYCLES(WDOG), .PULSE_CYCLES(PULSE),
      .DEB_CYCLES(DEB)) u_rrn_top (.clk(clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .net_rx(net_rx), .net_tx(net_tx),
      .net_tx_en(net_tx_en), .sw_baud_slow(sw_baud_slow), .sw_pulse_en(sw_pulse_en),
      .sw_wdog_en(sw_wdog_en), .status_input_one(status_input_one),
      .status_input_two(status_input_two), .relay_on(relay_on));

   rrn_master_model u_master (.clk(clk), .div(div), .net_tx(net_tx), .net_tx_en(net_tx_en), .net_rx(net_rx));

   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #240000;
      mismatches++;
      end_sim();
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // one bus access, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      n = 0;
      // waitrequest and read data are taken at the rising edge that completes the access
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      q = avs_readdata;
      if (n >= 100) mismatches++;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   task automatic rly(input logic exp);
      chk({31'h0, relay_on}, {31'h0, exp});
   endtask

   // sends one message, then waits for the reply if one is due
   task automatic msg(input logic [9:0] addr, input logic [7:0] cmd, input logic [2:0] st, input logic reply);
      int c;
      c = u_master.reply_cnt;
      u_master.send_msg(addr, cmd);
      for (int i = 0; i < 14 * div && u_master.reply_cnt == c; i++) @(posedge clk);
      repeat (div) @(posedge clk);
      chk(32'(u_master.reply_cnt - c), reply ? 32'h1 : 32'h0);
      if (reply) chk({24'h0, u_master.reply_byte}, {24'h0, `RRN_RPL_TAG, st});
      if (reply) chk({31'h0, u_master.reply_stop}, 32'h1);
   endtask

   initial begin
      resetn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_byteenable = 4'hF;
      avs_writedata = 32'h0;
      sw_baud_slow = 1'b0;
      sw_pulse_en = 1'b0;
      sw_wdog_en = 1'b0;
      status_input_one = 1'b0;
      status_input_two = 1'b0;
      div = FDIV;
      mismatches = 0;
      checked = 0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      // reset values, read-only and unmapped places, address write
      rdc(`RRN_REG_NODE_ADDR, 32'h1);
      rdc(`RRN_REG_STATUS, 32'h0);
      rdc(`RRN_REG_MSG_COUNT, 32'h0);
      rdc(4'hC, 32'h0);
      wr(`RRN_REG_STATUS, 32'hFFFFFFFF);
      rdc(`RRN_REG_STATUS, 32'h0);
      wr(`RRN_REG_NODE_ADDR, 32'h3E7);
      rdc(`RRN_REG_NODE_ADDR, 32'h3E7);
      // low lane only, then restore the full address
      avs_byteenable <= 4'h1;
      wr(`RRN_REG_NODE_ADDR, 32'h0);
      avs_byteenable <= 4'hF;
      rdc(`RRN_REG_NODE_ADDR, 32'h300);
      wr(`RRN_REG_NODE_ADDR, 32'h3E7);
      // on command to this node, then one to another node
      status_input_one <= 1'b1;
      repeat (20) @(posedge clk);
      msg(10'h3E7, `RRN_CMD_ON, 3'h3, 1'b1);
      rly(1'b1);
      // a two-cycle glitch on the second input must not reach the status
      status_input_two <= 1'b1;
      repeat (2) @(posedge clk);
      status_input_two <= 1'b0;
      rdc(`RRN_REG_STATUS, 32'h3);
      msg(10'h3E6, `RRN_CMD_OFF, 3'h0, 1'b0);
      msg(10'h3E7, 8'h03, 3'h0, 1'b0);
      rly(1'b1);
      rdc(`RRN_REG_MSG_COUNT, 32'h1);
      // silence with the watchdog off, then on
      repeat (WDOG + 100) @(posedge clk);
      rly(1'b1);
      sw_wdog_en <= 1'b1;
      repeat (WDOG + DEB + 100) @(posedge clk);
      rly(1'b0);
      rdc(`RRN_REG_STATUS, 32'h8A);
      // polls inside the interval keep the relay on
      msg(10'h3E7, `RRN_CMD_ON, 3'h3, 1'b1);
      for (int k = 0; k < 4; k++) begin
         repeat (WDOG / 2) @(posedge clk);
         msg(10'h3E7, `RRN_CMD_POLL, 3'h3, 1'b1);
      end
      rly(1'b1);
      msg(10'h3E7, `RRN_CMD_OFF, 3'h2, 1'b1);
      rdc(`RRN_REG_MSG_COUNT, 32'h7);
      // pulse mode: on for the pulse time, then off unaided
      sw_wdog_en <= 1'b0;
      sw_pulse_en <= 1'b1;
      repeat (DEB + 20) @(posedge clk);
      msg(10'h3E7, `RRN_CMD_ON, 3'h3, 1'b1);
      repeat (PULSE - 400) @(posedge clk);
      rly(1'b1);
      rdc(`RRN_REG_STATUS, 32'h53);
      repeat (400) @(posedge clk);
      rly(1'b0);
      // slow rate with the other status input
      sw_pulse_en <= 1'b0;
      sw_baud_slow <= 1'b1;
      status_input_one <= 1'b0;
      status_input_two <= 1'b1;
      div <= SDIV;
      repeat (DEB + 20) @(posedge clk);
      msg(10'h3E7, `RRN_CMD_POLL, 3'h4, 1'b1);
      rdc(`RRN_REG_STATUS, 32'h24);
      end_sim();
   end
endmodule

bind rrn_top rrn_properties #(.BAUD_FAST_DIV(BAUD_FAST_DIV), .BAUD_SLOW_DIV(BAUD_SLOW_DIV),
   .WDOG_CYCLES(WDOG_CYCLES), .PULSE_CYCLES(PULSE_CYCLES), .DEB_CYCLES(DEB_CYCLES)) u_props (
   .clk(clk), .resetn(resetn), .net_rx(net_rx), .net_tx(net_tx), .net_tx_en(net_tx_en),
   .sw_baud_slow(sw_baud_slow), .sw_pulse_en(sw_pulse_en), .sw_wdog_en(sw_wdog_en), .relay_on(relay_on));

`default_nettype wire
